// file: design/uart_rx_defines.svh
// offsets, field positions, reset values and counts of the receive error block
// assumes a 32-bit byte address on the register port
`ifndef UART_RX_DEFINES_SVH
`define UART_RX_DEFINES_SVH

`define ADDR_RX_QUEUE_HEAD     32'h4000_8000
`define ADDR_QUEUE_CONTROL     32'h4000_8008
`define ADDR_FRAME_FORMAT      32'h4000_800c
`define ADDR_BAUD_DIVISOR      32'h4000_8010
`define ADDR_RX_LINE_CONDITION 32'h4000_8014
`define ADDR_EVENT_STATUS      32'h4000_8018
`define ADDR_EVENT_MASK        32'h4000_801c

`define POS_STOP_BIT_FAULT     3
`define POS_LINE_HELD_LOW      4
`define POS_QUEUE_ENABLE       0
`define POS_PARITY_ENABLE      3
`define POS_EV_FAULT           0
`define POS_EV_BREAK           1

`define RST_QUEUE_CONTROL      8'h00
`define RST_FRAME_FORMAT       8'h03
`define RST_BAUD_DIVISOR       16'h0001
`define RST_EVENT_MASK         2'h0

`define OVERSAMPLE             5'h10
`define HALF_BIT               5'h08

`endif

// file: design/uart_rx_pkg.sv
// types of the receive error block
// assumes uart_rx_defines.svh for the numbers
package uart_rx_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP   = 3'b100,
    ST_BREAK  = 3'b101
  } rx_state_t;

  typedef struct packed {
    logic       line_held_low;
    logic       stop_bit_fault;
    logic [7:0] data;
  } rx_entry_t;

endpackage

// file: design/uart_rx_frame_break_detect.sv
// serial receiver with stop-bit fault and break detection, receive queue and status
// assumes one clock, a plain register port and an asynchronous serial line on serial_in_pin
//
// Summary of operation
// [RL1] low stop bit sets stop-bit fault flag
// [RL2] status read clears fault flag bit 3
// [RL3] fault visibility timing follows queue enable bit
// [RL4] low stop bit restarts as early start
// [RL5] fault flag belongs to queue head character
// [RL6] fault flag zero after reset, one pending
// [RL7] line low whole character signals break
// [RL8] after break idle until line high
// [RL9] status read clears break flag bit 4
// [RL10] break visibility timing follows queue enable bit
// [RL11] break flag belongs to queue head character
// [RL12] break flag zero after reset, idle
// [RL13] flags stored with character in queue
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "uart_rx_defines.svh"

module uart_rx_frame_break_detect
  import uart_rx_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        serial_in_pin,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             irq
);

  localparam int PW = $clog2(DEPTH);

  // ************************************************************
  // input synchroniser
  // ************************************************************
  logic rx_meta;
  logic rx_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_s    <= 1'b1;
    end else begin
      rx_meta <= serial_in_pin;
      rx_s    <= rx_meta;
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  logic [7:0]  queue_control;
  logic [7:0]  frame_format;
  logic [15:0] baud_divisor;
  logic [1:0]  event_mask;
  logic        fifo_en;

  assign fifo_en = queue_control[`POS_QUEUE_ENABLE];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      queue_control <= `RST_QUEUE_CONTROL;
      frame_format  <= `RST_FRAME_FORMAT;
      baud_divisor  <= `RST_BAUD_DIVISOR;
      event_mask    <= `RST_EVENT_MASK;
    end else if (wr) begin
      if (addr == `ADDR_QUEUE_CONTROL)
        queue_control <= wdata[7:0];
      if (addr == `ADDR_FRAME_FORMAT)
        frame_format <= wdata[7:0];
      if (addr == `ADDR_BAUD_DIVISOR)
        baud_divisor <= (wdata[15:0] == 16'h0000) ? 16'h0001 : wdata[15:0];
      if (addr == `ADDR_EVENT_MASK)
        event_mask <= wdata[1:0];
    end
  end

  // ************************************************************
  // oversample tick
  // ************************************************************
  logic [15:0] div_cnt;
  logic        tick;

  assign tick = (div_cnt == baud_divisor - 16'h0001);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      div_cnt <= 16'h0000;
    else if (tick)
      div_cnt <= 16'h0000;
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  // ************************************************************
  // receive state machine
  // ************************************************************
  rx_state_t  state;
  logic [4:0] phase;
  logic [2:0] bit_idx;
  logic [7:0] shift;
  logic       any_high;
  logic       mid_bit;
  logic [2:0] last_bit;
  logic       char_done;
  rx_entry_t  char_entry;

  // word length 5..8 from the two low format bits
  assign last_bit = {1'b1, frame_format[1:0]};
  assign mid_bit  = tick && (phase == ((state == ST_START) ? `HALF_BIT : `OVERSAMPLE) - 5'h01);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      phase      <= 5'h00;
      bit_idx    <= 3'h0;
      shift      <= 8'h00;
      any_high   <= 1'b0;
      char_done  <= 1'b0;
      char_entry <= '0;
    end else begin
      char_done <= 1'b0;
      if (tick)
        phase <= mid_bit ? 5'h00 : phase + 5'h01;
      unique case (state)
        ST_IDLE: begin
          phase <= 5'h00;
          if (!rx_s)
            state <= ST_START;
        end
        ST_START: begin
          if (mid_bit) begin
            if (rx_s) begin
              state <= ST_IDLE;
            end else begin
              state    <= ST_DATA;
              bit_idx  <= 3'h0;
              shift    <= 8'h00;
              any_high <= 1'b0;
            end
          end
        end
        ST_DATA: begin
          if (mid_bit) begin
            shift[bit_idx] <= rx_s;
            any_high       <= any_high | rx_s;
            bit_idx        <= bit_idx + 3'h1;
            if (bit_idx == last_bit)
              state <= frame_format[`POS_PARITY_ENABLE] ? ST_PARITY : ST_STOP;
          end
        end
        ST_PARITY: begin
          if (mid_bit) begin
            any_high <= any_high | rx_s;
            state    <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (mid_bit) begin
            char_done                <= 1'b1;
            char_entry.data          <= shift;
            char_entry.stop_bit_fault <= !rx_s; // RL1
            char_entry.line_held_low <= !rx_s && !any_high; // RL7
            if (rx_s) begin
              state <= ST_IDLE;
            end else if (!any_high) begin
              state <= ST_BREAK; // RL8
            end else begin
              // bad stop bit is taken as the middle of a new start bit
              state    <= ST_DATA; // RL4
              bit_idx  <= 3'h0;
              shift    <= 8'h00;
              any_high <= 1'b0;
            end
          end
        end
        ST_BREAK: begin
          phase <= 5'h00;
          if (rx_s)
            state <= ST_IDLE; // RL8
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // receive queue
  // ************************************************************
  rx_entry_t mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  logic          push;
  logic          pop;
  logic          head_new;
  logic          head_new_q;
  rx_entry_t     head;

  // without the queue only one holding slot is used
  assign push = char_done && (fifo_en ? (count < (PW+1)'(DEPTH)) : (count == '0));
  assign pop  = rd && (addr == `ADDR_RX_QUEUE_HEAD) && (count != '0);
  assign head = mem[rd_ptr];
  assign head_new = (push && count == '0) || (pop && (count > (PW+1)'(1) || push));

  always_ff @(posedge clk) begin
    if (push)
      mem[wr_ptr] <= char_entry; // RL13
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      head_new_q <= 1'b0;
    end else begin
      head_new_q <= head_new;
      if (push)
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      if (push && !pop)
        count <= count + (PW+1)'(1);
      else if (pop && !push)
        count <= count - (PW+1)'(1);
    end
  end

  // ************************************************************
  // line condition flags
  // ************************************************************
  logic stop_bit_fault_flag;
  logic line_held_low_flag;
  logic lsr_read;
  logic set_fault;
  logic set_break;

  assign lsr_read = rd && (addr == `ADDR_RX_LINE_CONDITION);
  // queued: flag shows when its character reaches the head; direct: at detection
  assign set_fault = fifo_en ? (head_new_q && head.stop_bit_fault) // RL3 RL5
                             : (char_done && char_entry.stop_bit_fault);
  assign set_break = fifo_en ? (head_new_q && head.line_held_low) // RL10 RL11
                             : (char_done && char_entry.line_held_low);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      stop_bit_fault_flag <= 1'b0; // RL6
    else if (set_fault)
      stop_bit_fault_flag <= 1'b1; // RL6
    else if (lsr_read)
      stop_bit_fault_flag <= 1'b0; // RL2
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      line_held_low_flag <= 1'b0; // RL12
    else if (set_break)
      line_held_low_flag <= 1'b1;
    else if (lsr_read)
      line_held_low_flag <= 1'b0; // RL9
  end

  // ************************************************************
  // interrupt events
  // ************************************************************
  logic [1:0] event_status;
  logic       ev_read;

  assign ev_read = rd && (addr == `ADDR_EVENT_STATUS);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_status <= 2'h0;
    end else begin
      if (ev_read)
        event_status <= 2'h0;
      if (set_fault)
        event_status[`POS_EV_FAULT] <= 1'b1;
      if (set_break)
        event_status[`POS_EV_BREAK] <= 1'b1;
    end
  end

  assign irq = |(event_status & event_mask);

  // ************************************************************
  // read data
  // ************************************************************
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (addr)
      `ADDR_RX_QUEUE_HEAD:
        next_rdata[7:0] = (count != '0) ? head.data : 8'h00;
      `ADDR_QUEUE_CONTROL:     next_rdata[7:0]  = queue_control;
      `ADDR_FRAME_FORMAT:      next_rdata[7:0]  = frame_format;
      `ADDR_BAUD_DIVISOR:      next_rdata[15:0] = baud_divisor;
      `ADDR_RX_LINE_CONDITION: begin
        next_rdata[`POS_STOP_BIT_FAULT] = stop_bit_fault_flag;
        next_rdata[`POS_LINE_HELD_LOW]  = line_held_low_flag;
      end
      `ADDR_EVENT_STATUS:      next_rdata[1:0]  = event_status;
      `ADDR_EVENT_MASK:        next_rdata[1:0]  = event_mask;
      default:                 next_rdata       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rdata <= 32'h0000_0000;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= 32'h0000_0000;
  end

endmodule

// file: testbench/rx_error_checker.sv
// concurrent checks of the receive error block, bound to its top module
// assumes one clock domain and the plain register port
`timescale 1ns/1ps
`include "uart_rx_defines.svh"

module rx_error_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        serial_in_pin,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        irq
);
  // ****************************************
  // helper state
  // ****************************************
  localparam logic [31:0] LC = `ADDR_RX_LINE_CONDITION;
  logic [4:0] quiet;
  logic       seen_low;
  logic [1:0] mask_copy;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // cycles with the line high and no pop, so no flag can be set meanwhile
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet <= 5'h00;
    end else if (!serial_in_pin || (rd && addr == `ADDR_RX_QUEUE_HEAD)) begin
      quiet <= 5'h00;
    end else if (quiet != 5'h1f) begin
      quiet <= quiet + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_low <= 1'b0;
    end else if (!serial_in_pin) begin
      seen_low <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_copy <= 2'h0;
    end else if (wr && addr == `ADDR_EVENT_MASK) begin
      mask_copy <= wdata[1:0];
    end
  end

  sequence s_lc_read;
    rd && addr == LC;
  endsequence
  sequence s_quiet_lc_read;
    rd && addr == LC && quiet >= 5'h0c;
  endsequence

  property p_lc_clear;
    s_quiet_lc_read ##1 s_lc_read |=> rdata[4:3] == 2'b00;
  endproperty
  a_lc_clear: assert property (p_lc_clear) else $error("status flags survived a read");
  property p_lc_layout;
    s_lc_read |=> rdata[31:5] == 27'h0 && rdata[2:0] == 3'h0;
  endproperty
  a_lc_layout: assert property (p_lc_layout) else $error("status bits out of place");
  property p_reset_flags;
    rd && addr == LC && !seen_low |=> rdata[4:3] == 2'b00;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flag set without traffic");
  property p_brk_fault;
    s_lc_read ##1 rdata[4] |-> rdata[3];
  endproperty
  a_brk_fault: assert property (p_brk_fault) else $error("break without stop fault");
  property p_rdata_idle;
    !rd |=> rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_unmapped;
    rd && addr[31:8] != 24'h400080 |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_clear;
    rd && addr == `ADDR_EVENT_STATUS && quiet >= 5'h0c |=> !irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt held after status read");
  property p_irq_mask;
    mask_copy == 2'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt while fully masked");
endmodule

bind uart_rx_frame_break_detect rx_error_checker chk_i (
  .clk(clk), .rst_n(rst_n), .serial_in_pin(serial_in_pin), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq)
);

// file: testbench/serial_tx_model.sv
// remote serial transmitter driving the receive line
// assumes divisor 1, so 16 clocks per bit, 8 data bits, no parity
`timescale 1ns/1ps

module serial_tx_model (
  input  wire logic clk,
  output logic      line
);
  // ****************************************
  // frame generation
  // ****************************************
  localparam int BIT_CLKS = 16;

  // idle line is marking (high)
  initial line = 1'b1;

  task automatic hold(input logic v, input int bits);
    line <= v;
    repeat (bits * BIT_CLKS) @(posedge clk);
  endtask

  // a bad stop leaves room for the resync frame that follows it
  task automatic send(input logic [7:0] data, input logic stop_ok);
    @(posedge clk);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) hold(data[i], 1);
    hold(stop_ok, 1);
    hold(1'b1, stop_ok ? 2 : 12);
  endtask

  task automatic send_break();
    @(posedge clk);
    hold(1'b0, 12);
    hold(1'b1, 4);
  endtask
endmodule

// file: testbench/tb.sv
// self-checking bench of the receive error block
// assumes the transmitter model and the bound checker
`timescale 1ns/1ps
`include "uart_rx_defines.svh"

module tb;
  // ****************************************
  // bench
  // ****************************************
  localparam logic [31:0] LC  = `ADDR_RX_LINE_CONDITION;
  localparam logic [31:0] FLT = 32'h1 << `POS_STOP_BIT_FAULT;
  localparam logic [31:0] BRK = 32'h1 << `POS_LINE_HELD_LOW;
  logic clk, rst_n, wr, rd, irq, serial_line;
  logic [31:0] addr, wdata, rdata;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] reg_addr [5] = '{`ADDR_QUEUE_CONTROL, `ADDR_FRAME_FORMAT,
                               `ADDR_BAUD_DIVISOR, `ADDR_EVENT_MASK, 32'h4000_9000};
  logic [31:0] reg_rst [5] = '{32'(`RST_QUEUE_CONTROL), 32'(`RST_FRAME_FORMAT),
                              32'(`RST_BAUD_DIVISOR), 32'(`RST_EVENT_MASK), 32'h0};

  uart_rx_frame_break_detect #(.DEPTH(16)) dut (.clk(clk), .rst_n(rst_n),
    .serial_in_pin(serial_line), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq));
  serial_tx_model tx (.clk(clk), .line(serial_line));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask

  // two reads back to back: flags, then cleared
  task automatic lc_chk(input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= LC;
    @(posedge clk);
    #1;
    chk("line_condition", exp, rdata);
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("line_condition_cleared", 32'h0, rdata);
  endtask

  task automatic pop_chk(input logic [7:0] exp);
    rd_chk("queue_head", `ADDR_RX_QUEUE_HEAD, {24'h0, exp});
    repeat (16) @(posedge clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    wrap_up;
  end

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 32'h0;
    wdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    lc_chk(32'h0);
    for (int i = 0; i < 5; i++) rd_chk("reset_value", reg_addr[i], reg_rst[i]);
    reg_wr(32'h4000_9000, 32'hffff_ffff);
    rd_chk("unmapped", 32'h4000_9000, 32'h0);
    // single holding slot
    tx.send(8'h5a, 1'b0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    lc_chk(FLT);
    pop_chk(8'h5a);
    // queue enabled
    reg_wr(`ADDR_QUEUE_CONTROL, 32'h1);
    tx.send(8'ha5, 1'b1);
    tx.send(8'h3c, 1'b0);
    lc_chk(32'h0);
    pop_chk(8'ha5);
    lc_chk(FLT);
    pop_chk(8'h3c);
    lc_chk(32'h0);
    pop_chk(8'hff);
    rd_chk("event_status", `ADDR_EVENT_STATUS, 32'h1);
    reg_wr(`ADDR_EVENT_MASK, 32'h3);
    tx.send_break();
    chk("irq_raised", 32'h1, {31'h0, irq});
    lc_chk(FLT | BRK);
    rd_chk("event_status", `ADDR_EVENT_STATUS, 32'h3);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    pop_chk(8'h00);
    rd_chk("queue_empty", `ADDR_RX_QUEUE_HEAD, 32'h0);
    lc_chk(32'h0);
    // ten low bit times: a break without parity, a clean zero with the parity slot
    reg_wr(`ADDR_FRAME_FORMAT, 32'h0b);
    tx.hold(1'b0, 10);
    tx.hold(1'b1, 4);
    lc_chk(32'h0);
    pop_chk(8'h00);
    wrap_up;
  end
endmodule
